// ---- core/usr_pkg.sv ----
package usr_pkg;
    localparam logic [31:0] UART0_BASE  = 32'hFFFF_F500; // First instance
    localparam logic [31:0] UART1_BASE  = 32'hFFFF_F600; // Second instance
    localparam logic [4:0]  OFS_DATA    = 5'h00;  // Data or divisor low
    localparam logic [4:0]  OFS_IEN     = 5'h04;  // Enable or divisor high
    localparam logic [4:0]  OFS_SRC     = 5'h08;  // Source / queue control
    localparam logic [4:0]  OFS_FMT     = 5'h0C;  // Line format
    localparam logic [4:0]  OFS_MOUT    = 5'h10;  // Modem outputs
    localparam logic [4:0]  OFS_LST     = 5'h14;  // Line state
    localparam logic [4:0]  OFS_MIN     = 5'h18;  // Modem inputs
    localparam logic [4:0]  OFS_SCR     = 5'h1C;  // Scratch pad
    localparam int          FMT_DAS     = 7;      // Divisor access select
    localparam int          FMT_BRK     = 6;      // Break control
    localparam int          FMT_PEN     = 3;      // Parity enable
    localparam int          FMT_EPS     = 4;      // Even parity
    localparam int          FMT_STK     = 5;      // Stick parity
    localparam int          FMT_STB     = 2;      // Stop bits
    localparam int          LST_DR      = 0;      // Data ready
    localparam int          LST_OE      = 1;      // Overrun
    localparam int          LST_THRE    = 5;      // Holding empty
    localparam int          LST_TEMT    = 6;      // Transmitter empty
    localparam logic [7:0]  SRC_RST     = 8'h01;  // No interrupt pending
    localparam logic [7:0]  LST_RST     = 8'h60;  // Both empties set
    localparam logic [7:0]  ZERO8       = 8'h00;  // Generic clear
    localparam logic [3:0]  OVS         = 4'hF;   // 16x oversample top
    localparam logic [3:0]  OVS_MID     = 4'h7;   // Mid-bit sample point
    localparam logic [2:0]  LEN_BASE    = 3'h5;   // Shortest character
endpackage : usr_pkg

// ---- core/usr_buf2.sv ----
`timescale 1ns/1ps
// Two-entry skid buffer between transmit holding and shifter
module usr_buf2 import usr_pkg::*; #(
    parameter int W = 8                  // Word width
) (
    input  wire logic         clk_sys,   // System clock
    input  wire logic         rst_b,     // Async reset, low
    input  wire logic         ce,        // Clock enable
    input  wire logic         in_valid,  // Word offered
    output logic              in_ready,  // Space available
    input  wire logic [W-1:0] in_data,   // Word in
    output logic              out_valid, // Word available
    input  wire logic         out_ready, // Drain accepts
    output logic [W-1:0]      out_data   // Oldest word
);
    initial if (W < 1) $error("usr_buf2: W must be positive");
    logic [W-1:0] mem_reg [2];           // Storage, index addressed
    logic [W-1:0] mem_next [2];          // Next storage
    logic [1:0]   cnt_reg, cnt_next;     // Fill level 0..2
    logic         rd_reg, rd_next;       // Read index
    logic         wr_reg, wr_next;       // Write index
    assign in_ready  = (cnt_reg != 2'd2);
    assign out_valid = (cnt_reg != 2'd0);
    assign out_data  = mem_reg[rd_reg];
    // Next-state: push and pop may coincide
    always_comb
    begin
        mem_next = mem_reg;
        cnt_next = cnt_reg;
        rd_next  = rd_reg;
        wr_next  = wr_reg;
        if (in_valid && in_ready)
        begin
            mem_next[wr_reg] = in_data;
            wr_next = ~wr_reg;
        end
        if (out_valid && out_ready)
            rd_next = ~rd_reg;
        cnt_next = cnt_reg + 2'(in_valid && in_ready)
                 - 2'(out_valid && out_ready);
    end
    // Registers only
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            cnt_reg    <= 2'd0;
            rd_reg     <= 1'b0;
            wr_reg     <= 1'b0;
        end
        else if (ce)
        begin
            mem_reg <= mem_next;
            cnt_reg <= cnt_next;
            rd_reg  <= rd_next;
            wr_reg  <= wr_next;
        end
    end
    AST_NO_OVERFLOW: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cnt_reg <= 2'd2) else $error("buffer level out of range");
endmodule : usr_buf2

// ---- core/usr_port.sv ----
`timescale 1ns/1ps
// One serial port register set; instantiate twice with each base
module usr_port import usr_pkg::*; #(
    parameter logic [31:0] BASE = UART0_BASE  // Instance base
) (
    input  wire logic        clk_sys,   // System clock
    input  wire logic        rst_b,     // Async reset, low
    input  wire logic        ce,        // Clock enable
    input  wire logic [31:0] addr,      // Bus address
    input  wire logic        sel,       // Access strobe
    input  wire logic        wr,        // 1 write, 0 read
    input  wire logic [7:0]  wdata,     // Write data
    output logic [7:0]       rdata,     // Read data, registered
    input  wire logic        serial_in, // Line input, async
    output logic             serial_out,// Line output
    output logic             rts_b,     // Request to send, low
    output logic             dtr_b      // Terminal ready, low
);
    initial if (BASE[4:0] != 5'h00) $error("usr_port: base misaligned");
    // Register state
    logic [7:0]  ien_reg, fmt_reg, mout_reg, scr_reg, qctl_reg, rxb_reg;
    logic [15:0] div_reg;                // Baud divisor
    logic [15:0] bcnt_reg, bcnt_next;    // Baud counter
    logic        tick;                   // 16x enable
    logic        dr_reg, oe_reg;         // Receive status
    logic [7:0]  rdata_next;             // Read mux
    logic        hit;                    // Address in range
    logic [4:0]  ofs;                    // Offset in block
    logic        das;                    // Divisor access select
    assign ofs = addr[4:0];
    assign hit = sel && (addr[31:5] == BASE[31:5]);
    assign das = fmt_reg[FMT_DAS];
    // Character length and parity from format
    function automatic logic [3:0] char_len(input logic [1:0] code);
        char_len = 4'(LEN_BASE) + 4'(code);
    endfunction : char_len
    function automatic logic par_bit(input logic [7:0] f,
                                     input logic [7:0] d);
        if (f[FMT_STK]) par_bit = ~f[FMT_EPS];
        else par_bit = ^d ^ ~f[FMT_EPS];
    endfunction : par_bit
    // Input synchroniser: three stages, accept when last two agree
    logic [2:0] sync_reg;
    logic       rx_reg;                  // Filtered line level
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b) begin sync_reg <= 3'b111; rx_reg <= 1'b1; end
        else if (ce)
        begin
            sync_reg <= {sync_reg[1:0], serial_in};
            if (sync_reg[2] == sync_reg[1]) rx_reg <= sync_reg[2];
        end
    end
    // Baud counter, reloaded on any divisor write
    logic div_wr;
    assign div_wr = hit && wr && das && (ofs == OFS_DATA || ofs == OFS_IEN);
    always_comb
    begin
        if (div_wr) bcnt_next = (ofs == OFS_DATA) ? {div_reg[15:8], wdata}
                                                  : {wdata, div_reg[7:0]};
        else if (bcnt_reg <= 16'd1) bcnt_next = div_reg;
        else bcnt_next = bcnt_reg - 16'd1;
    end
    assign tick = (bcnt_reg == 16'd1) && !div_wr;
    // Transmit path through two-entry buffer
    logic       thr_push, thr_rdy, tq_v, tq_pop;
    logic [7:0] tq_d;
    assign thr_push = hit && wr && !das && ofs == OFS_DATA;
    usr_buf2 #(.W(8)) u_buf (
        .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
        .in_valid(thr_push), .in_ready(thr_rdy), .in_data(wdata),
        .out_valid(tq_v), .out_ready(tq_pop), .out_data(tq_d));
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} usr_tx_t;
    usr_tx_t    tx_st;
    logic [7:0] tx_sh;
    logic [3:0] tx_ov, tx_n;
    logic       tx_par_done;
    assign tq_pop = ce && (tx_st == TX_IDLE);
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_st <= TX_IDLE; tx_sh <= ZERO8; tx_ov <= 4'h0; tx_n <= 4'h0;
            tx_par_done <= 1'b0; serial_out <= 1'b1;
        end
        else if (ce)
        begin
            unique case (tx_st)
                TX_IDLE: if (tq_v)
                begin
                    tx_sh <= tq_d; tx_st <= TX_START; tx_ov <= 4'h0;
                    tx_n <= 4'h0; tx_par_done <= 1'b0;
                end
                TX_START: if (tick)
                begin
                    tx_ov <= tx_ov + 4'h1;
                    if (tx_ov == OVS) tx_st <= TX_DATA;
                end
                TX_DATA: if (tick)
                begin
                    tx_ov <= tx_ov + 4'h1;
                    if (tx_ov == OVS)
                    begin
                        if (tx_n + 4'h1 < char_len(fmt_reg[1:0]))
                        begin
                            tx_n <= tx_n + 4'h1;
                            tx_sh <= tx_sh >> 1;
                        end
                        else if (fmt_reg[FMT_PEN] && !tx_par_done)
                            tx_par_done <= 1'b1;
                        else tx_st <= TX_STOP;
                    end
                end
                TX_STOP: if (tick)
                begin
                    tx_ov <= tx_ov + 4'h1;
                    if (tx_ov == OVS) tx_st <= TX_IDLE;
                end
            endcase
            serial_out <= fmt_reg[FMT_BRK] ? 1'b0 :
                (tx_st == TX_START) ? 1'b0 :
                (tx_st == TX_DATA) ? (tx_par_done ?
                    par_bit(fmt_reg, tx_sh) : tx_sh[0]) : 1'b1;
        end
    end
    // Receiver: LSB first, mid-bit sampling
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usr_rx_t;
    usr_rx_t    rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_ov, rx_n;
    logic       rx_done;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_st <= RX_IDLE; rx_sh <= ZERO8; rx_ov <= 4'h0;
            rx_n <= 4'h0; rx_done <= 1'b0;
        end
        else if (ce)
        begin
            rx_done <= 1'b0;
            unique case (rx_st)
                RX_IDLE: if (!rx_reg)
                begin
                    rx_st <= RX_START; rx_ov <= 4'h0; rx_n <= 4'h0;
                    rx_sh <= ZERO8;          // Short characters read zero
                end
                RX_START: if (tick)
                begin
                    rx_ov <= rx_ov + 4'h1;
                    if (rx_ov == OVS_MID)
                    begin
                        rx_ov <= 4'h0;
                        rx_st <= rx_reg ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: if (tick)
                begin
                    rx_ov <= rx_ov + 4'h1;
                    if (rx_ov == OVS)
                    begin
                        // Parity bit must not land in bit zero
                        if (rx_n < char_len(fmt_reg[1:0]))
                            rx_sh[rx_n[2:0]] <= rx_reg;
                        rx_n <= rx_n + 4'h1;
                        if (rx_n + 4'h1 == char_len(fmt_reg[1:0]) +
                            4'(fmt_reg[FMT_PEN])) rx_st <= RX_STOP;
                    end
                end
                RX_STOP: if (tick)
                begin
                    rx_ov <= rx_ov + 4'h1;
                    if (rx_ov == OVS)
                    begin
                        rx_st <= RX_IDLE; rx_done <= 1'b1;
                    end
                end
            endcase
        end
    end
    // Register writes and status; arrival beats read-clear
    logic rbr_rd;
    assign rbr_rd = hit && !wr && !das && ofs == OFS_DATA;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ien_reg <= ZERO8; fmt_reg <= ZERO8; mout_reg <= ZERO8;
            scr_reg <= ZERO8; qctl_reg <= ZERO8; rxb_reg <= ZERO8;
            div_reg <= 16'h0000; bcnt_reg <= 16'h0000;
            dr_reg <= 1'b0; oe_reg <= 1'b0; rdata <= ZERO8;
            rts_b <= 1'b1; dtr_b <= 1'b1;
        end
        else if (ce)
        begin
            bcnt_reg <= bcnt_next;
            rdata <= rdata_next;
            rts_b <= ~mout_reg[1] | mout_reg[4];
            dtr_b <= ~mout_reg[0] | mout_reg[4];
            if (hit && wr)
            begin
                unique case (ofs)
                    OFS_DATA: if (das) div_reg[7:0] <= wdata;
                    OFS_IEN:  if (das) div_reg[15:8] <= wdata;
                              else ien_reg <= {4'h0, wdata[3:0]};
                    OFS_SRC:  qctl_reg <= wdata;
                    OFS_FMT:  fmt_reg <= wdata;
                    OFS_MOUT: mout_reg <= {3'h0, wdata[4:0]};
                    OFS_SCR:  scr_reg <= wdata;
                    default:  ;
                endcase
            end
            if (rx_done)
            begin
                rxb_reg <= rx_sh; dr_reg <= 1'b1;
                if (dr_reg && !rbr_rd) oe_reg <= 1'b1;
            end
            else if (rbr_rd) dr_reg <= 1'b0;
            if (hit && !wr && ofs == OFS_LST && !rx_done) oe_reg <= 1'b0;
        end
    end
    // Read mux; source bits 7:6 always read zero
    logic [7:0] src_val, lst_val;
    assign src_val = (ien_reg[0] && dr_reg) ? 8'h04 :
                     (ien_reg[1] && thr_rdy && !tq_v) ? 8'h02 : SRC_RST;
    assign lst_val = {1'b0, tx_st == TX_IDLE && !tq_v, thr_rdy,
                      3'h0, oe_reg, dr_reg};
    always_comb
    begin
        rdata_next = rdata;
        if (hit && !wr)
        begin
            unique case (ofs)
                OFS_DATA: rdata_next = das ? div_reg[7:0] : rxb_reg;
                OFS_IEN:  rdata_next = das ? div_reg[15:8] : ien_reg;
                OFS_SRC:  rdata_next = {2'b00, src_val[5:0]};
                OFS_FMT:  rdata_next = fmt_reg;
                OFS_MOUT: rdata_next = mout_reg;
                OFS_LST:  rdata_next = lst_val;
                OFS_MIN:  rdata_next = ZERO8;
                OFS_SCR:  rdata_next = scr_reg;
                default:  rdata_next = ZERO8;
            endcase
        end
    end
    // Queue control write at the shared offset
    sequence seq_qctl_wr;
        ce && hit && wr && ofs == OFS_SRC;
    endsequence
    AST_SRC_TOP_ZERO:
        assert property (@(posedge clk_sys) disable iff (!rst_b)
            ce && hit && !wr && ofs == OFS_SRC |=> rdata[7:6] == 2'b00)
        else $error("source top bits not zero");
    AST_DIV_RELOAD:
        assert property (@(posedge clk_sys) disable iff (!rst_b)
            ce && div_wr && ofs == OFS_IEN |=>
            bcnt_reg[15:8] == $past(wdata))
        else $error("baud counter not reloaded");
    AST_NO_RBR_WRITE:
        assert property (@(posedge clk_sys) disable iff (!rst_b)
            ce && thr_push && !rx_done |=> $stable(rxb_reg))
        else $error("receive buffer changed by write");
    AST_QCTL_NO_SRC:
        assert property (@(posedge clk_sys) disable iff (!rst_b)
            seq_qctl_wr |=> $stable(ien_reg))
        else $error("queue write disturbed other state");
    AST_QCTL_STORE:
        assert property (@(posedge clk_sys) disable iff (!rst_b)
            seq_qctl_wr |=> qctl_reg == $past(wdata) && $stable(fmt_reg))
        else $error("queue control not stored alone");
endmodule : usr_port

// ---- verification/usr_peer_model.sv ----
`timescale 1ns/1ps
// Far-end serial peripheral, asynchronous line, bit zero first
module usr_peer_model #(
    parameter int BIT_CYC = 16          // Clocks per serial bit
) (
    input  wire logic clk_sys,          // System clock
    input  wire logic line_in,          // From port serial_out
    output logic      line_out          // To port serial_in
);
    // Idle line sits at the marking level
    initial line_out = 1'b1;
    // Capture one frame; waits are bounded so a dead line cannot hang
    task automatic rx_frame(input int nbits, output logic [7:0] d,
                            output bit ok);
        int i;
        d  = 8'h00;
        ok = 1'b0;
        for (i = 0; i < 4000 && !ok; i++)
        begin
            @(posedge clk_sys);
            ok = (line_in === 1'b0);
        end
        if (ok)
        begin
            repeat (BIT_CYC / 2) @(posedge clk_sys);
            for (i = 0; i < nbits; i++)
            begin
                repeat (BIT_CYC) @(posedge clk_sys);
                d[i] = line_in; // First sampled is bit zero
            end
            repeat (BIT_CYC) @(posedge clk_sys);
        end
    endtask : rx_frame
    // Send start, data bit zero first, then stop
    task automatic send_frame(input logic [7:0] d, input int nbits);
        int i;
        for (i = -1; i <= nbits; i++)
        begin
            @(posedge clk_sys);
            line_out <= (i < 0) ? 1'b0 : (i == nbits) ? 1'b1 : d[i];
            repeat (BIT_CYC - 1) @(posedge clk_sys);
        end
    endtask : send_frame
endmodule : usr_peer_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
// Two ports on one bus, a peer on port zero, port one looped back
module tb_top import usr_pkg::*;;
    logic       clk_sys;                // System clock
    logic       rst_b;                  // Reset, low
    logic [31:0] addr;                  // Shared bus address
    logic       sel;                    // Access strobe
    logic       wr;                     // Write select
    logic [7:0] wdata;                  // Write data
    logic [7:0] rdata0;                 // Port zero read data
    logic [7:0] rdata1;                 // Port one read data
    logic       sout0;                  // Port zero line out
    logic       sin0;                   // Peer line out
    logic       sout1;                  // Port one line out
    logic       rts_b0;                 // Port zero request
    logic       dtr_b0;                 // Port zero ready
    logic       rts_b1;                 // Port one request
    logic       dtr_b1;                 // Port one ready
    int         fail_count;             // Mismatches
    int         num_checks;             // Comparisons
    logic [7:0] rd;                     // Last read value
    logic [7:0] got;                    // Peer capture
    bit         ok;                     // Peer wait result
    int         k;                      // Loop index
    // Table rows: instance, offset, value
    logic       r_inst [6] = '{0, 1, 0, 1, 0, 1};
    logic [4:0] r_ofs  [6] = '{OFS_SCR, OFS_SCR, OFS_IEN, OFS_IEN,
                               OFS_MOUT, OFS_FMT};
    logic [7:0] r_val  [6] = '{8'hA5, 8'h5A, 8'h05, 8'h02, 8'h03, 8'h1B};

    usr_port #(.BASE(UART0_BASE)) usr_port_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1), .addr(addr),
        .sel(sel), .wr(wr), .wdata(wdata), .rdata(rdata0),
        .serial_in(sin0), .serial_out(sout0), .rts_b(rts_b0),
        .dtr_b(dtr_b0));
    // Second port, own base, own line looped to itself
    usr_port #(.BASE(UART1_BASE)) usr_port_inst1 (
        .clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1), .addr(addr),
        .sel(sel), .wr(wr), .wdata(wdata), .rdata(rdata1),
        .serial_in(sout1), .serial_out(sout1), .rts_b(rts_b1),
        .dtr_b(dtr_b1));
    usr_peer_model #(.BIT_CYC(16)) usr_peer_model_inst (
        .clk_sys(clk_sys), .line_in(sout0), .line_out(sin0));

    // Free-running 100 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Single comparison point
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    // One register access; strobe held one edge, read taken late
    task automatic acc(input logic inst, input logic w,
                       input logic [4:0] ofs, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= (inst ? UART1_BASE : UART0_BASE) + 32'(ofs);
        sel   <= 1'b1;
        wr    <= w;
        wdata <= d;
        @(posedge clk_sys);
        sel   <= 1'b0;
        @(posedge clk_sys);
        #1 rd = inst ? rdata1 : rdata0;
    endtask : acc
    // Frame check through the peer; a lost frame ends the run
    task automatic expect_frame(input int n, input logic [7:0] e);
        usr_peer_model_inst.rx_frame(n, got, ok);
        if (!ok)
        begin
            fail_count++;
            conclude();
        end
        else
            chk("line frame", e, got);
    endtask : expect_frame

    // Main sequence
    initial
    begin
        fail_count = 0;
        num_checks = 0;
        addr = 32'h0000_0000;
        sel = 1'b0;
        wr = 1'b0;
        wdata = 8'h00;
        rst_b = 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1 chk("pins idle", 8'h07, {5'h00, sout0, rts_b0, dtr_b0});
        acc(0, 0, OFS_LST, 8'h00);
        chk("line_state reset", LST_RST, rd);
        $display("reset test done");
        // Row loop: write all, then read back all
        for (k = 0; k < 6; k++) acc(r_inst[k], 1, r_ofs[k], r_val[k]);
        for (k = 0; k < 6; k++)
        begin
            acc(r_inst[k], 0, r_ofs[k], 8'h00);
            chk("row readback", r_val[k], rd);
        end
        chk("modem pins", 8'h00, {6'h00, rts_b0, dtr_b0});
        acc(0, 0, OFS_MIN, 8'h00);
        chk("modem_inputs", 8'h00, rd);
        // Port one access must leave port zero data standing
        acc(0, 0, OFS_SCR, 8'h00);
        acc(1, 0, OFS_SCR, 8'h00);
        chk("port one scratch", 8'h5A, rd);
        chk("port zero held", 8'hA5, rdata0);
        acc(0, 0, 5'h02, 8'h00);
        chk("unmapped", 8'h00, rd);
        $display("table test done");
        // Divisor bytes behind the select bit
        acc(0, 1, OFS_FMT, 8'h83);
        acc(0, 1, OFS_DATA, 8'h01);
        acc(0, 1, OFS_IEN, 8'h12);
        acc(0, 0, OFS_IEN, 8'h00);
        chk("divisor high", 8'h12, rd);
        acc(0, 1, OFS_IEN, 8'h00);
        acc(0, 0, OFS_DATA, 8'h00);
        chk("divisor low", 8'h01, rd);
        acc(0, 1, OFS_FMT, 8'h03);
        acc(0, 0, OFS_IEN, 8'h00);
        chk("enable kept", 8'h05, rd);
        $display("divisor test done");
        // Back-to-back holding writes, eight-bit then five-bit
        acc(0, 1, OFS_DATA, 8'hA5);
        acc(0, 1, OFS_DATA, 8'h3C);
        expect_frame(8, 8'hA5);
        expect_frame(8, 8'h3C);
        acc(0, 1, OFS_FMT, 8'h00);
        acc(0, 1, OFS_DATA, 8'hFF);
        expect_frame(5, 8'h1F);
        $display("transmit test done");
        // Reception in eight-bit mode
        acc(0, 1, OFS_FMT, 8'h03);
        usr_peer_model_inst.send_frame(8'h96, 8);
        k = 0;
        rd = 8'h00;
        while (k < 400 && rd[LST_DR] !== 1'b1)
        begin
            acc(0, 0, OFS_LST, 8'h00);
            k++;
        end
        if (k == 400)
        begin
            fail_count++;
            conclude();
        end
        else
            chk("data ready", 8'h01, {7'h00, rd[LST_DR]});
        acc(0, 0, OFS_SRC, 8'h00);
        chk("source data pending", 8'h04, rd);
        acc(0, 0, OFS_DATA, 8'h00);
        chk("receive_buffer", 8'h96, rd);
        $display("receive test done");
        // Break forces the line low, clearing it returns to marking
        acc(0, 1, OFS_FMT, 8'h43);
        chk("break line", 8'h00, {7'h00, sout0});
        acc(0, 1, OFS_FMT, 8'h03);
        chk("break cleared", 8'h01, {7'h00, sout0});
        $display("break test done");
        // Shared offset eight leaves format alone
        acc(0, 1, OFS_SRC, 8'hC7);
        acc(0, 0, OFS_SRC, 8'h00);
        chk("source high bits", 8'h00, rd & 8'hC0);
        chk("source none pending", SRC_RST, rd);
        acc(0, 0, OFS_FMT, 8'h00);
        chk("format kept", 8'h03, rd);
        $display("shared offset test done");
        // Mid-run reset brings back the reset values
        @(posedge clk_sys);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        rst_b <= 1'b1;
        acc(0, 0, OFS_FMT, 8'h00);
        chk("format after reset", 8'h00, rd);
        acc(0, 0, OFS_LST, 8'h00);
        chk("line_state after reset", LST_RST, rd);
        chk("modem pins after reset", 8'h03, {6'h00, rts_b0, dtr_b0});
        $display("mid-run reset test done");
        conclude();
    end
endmodule : tb_top
